/* File: hw/uart_alt_pkg.sv */
package uart_alt_pkg;
  localparam logic [7:0]  ALT_CSR_OFFSET   = 8'h2C;
  localparam logic [7:0]  FUNC_SELECT_OFFSET = 8'h30;
  localparam logic [31:0] ALT_CSR_RESET    = 32'h0000_000C;
  localparam logic [31:0] FUNC_SELECT_RESET  = 32'h0000_0000;
  localparam int          MATCH_LSB        = 24;
  localparam int          ADDR_EN_BIT      = 15;
  localparam int          AUTO_DIR_BIT     = 10;
  localparam int          AUTO_ADDR_BIT    = 9;
  localparam int          NORMAL_MD_BIT    = 8;
  localparam int          BREAK_REQ_BIT    = 7;
  localparam int          LIN_RX_BIT       = 6;
  localparam logic [3:0]  BREAK_LEN_RESET  = 4'hC;
  localparam logic [15:0] BIT_CYCLES_RESET = 16'h0010;

  typedef enum logic [1:0] {
    FUNC_UART  = 2'h0,
    FUNC_LIN   = 2'h1,
    FUNC_IRDA  = 2'h2,
    FUNC_RS485 = 2'h3
  } channel_function_t;

  typedef struct packed {
    logic [7:0] station_match;
    logic       multidrop_addr_detect_enable;
    logic       auto_direction_mode;
    logic       auto_address_detect_mode;
    logic       normal_multidrop_mode;
    logic       break_request;
    logic       lin_rx_enable;
    logic [3:0] break_length_count;
  } alt_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       is_address;
  } rx_byte_t;
endpackage

/* File: hw/uart_break_gen.sv */
`timescale 1ns/1ps
// sends a low break of (count + 1) bit times, one bit = bit_cycles clocks
module uart_break_gen (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // control
  input  wire logic        start_in,
  input  wire logic [3:0]  count_in,
  input  wire logic [15:0] bit_cycles_in,
  // status
  output logic             active_out,
  output logic             done_out
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [4:0]  bits_left;
    logic [15:0] cyc;
  } brk_state_t;

  brk_state_t s_q;
  brk_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy) begin
      if (start_in) begin
        s_d.busy      = 1'b1;
        s_d.bits_left = {1'b0, count_in} + 5'd1;
        s_d.cyc       = bit_cycles_in;
      end
    end else if (s_q.cyc <= 16'h0001) begin
      s_d.cyc = bit_cycles_in;
      if (s_q.bits_left == 5'd1) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      s_d.bits_left = s_q.bits_left - 5'd1;
    end else begin
      s_d.cyc = s_q.cyc - 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active_out = s_q.busy;
  assign done_out   = s_q.done;
endmodule

/* File: hw/uart_alt_function_control.sv */
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module uart_alt_function_control (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  // ahb-lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // bit time in clocks, from the baud generator
  input  wire logic [15:0] BIT_CYCLES_IN,
  // transmitter status
  input  wire logic        TX_FRAME_ACTIVE_IN,
  // received bytes from the shifter (9th bit marks an address)
  input  wire logic        RX_VALID_IN,
  input  wire logic [7:0]  RX_DATA_IN,
  input  wire logic        RX_IS_ADDR_IN,
  // line side
  output logic             TX_BREAK_OUT,
  output logic             TX_DIR_OUT,
  output logic             RX_VALID_OUT,
  output logic [7:0]       RX_DATA_OUT,
  output logic             ADDR_MATCHED_OUT,
  // mode outputs
  output logic [1:0]       CHANNEL_FUNCTION_OUT,
  output logic             LIN_RX_ENABLE_OUT
);
  typedef struct packed {
    uart_alt_pkg::alt_ctrl_t ctrl;
    logic [1:0]              func;
    logic                    dp_active;
    logic                    dp_write;
    logic [7:0]              dp_addr;
    logic [31:0]             rdata;
    logic                    start;
    logic                    matched;
    logic                    tx_dir;
    uart_alt_pkg::rx_byte_t  rx_out;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic       brk_active;
  logic       brk_done;
  logic       rs485_on;
  logic       accept;
  logic       word_access;
  logic       addr_req;
  logic       csr_sel;
  logic       fsel_sel;
  logic       dp_csr_wr;
  logic       dp_fsel_wr;

  // narrower transfers are not decoded: writes are dropped, reads return zero
  assign word_access = (HSIZE_IN == 3'h2);
  assign addr_req    = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign csr_sel     = (HADDR_IN[7:0] == uart_alt_pkg::ALT_CSR_OFFSET);
  assign fsel_sel    = (HADDR_IN[7:0] == uart_alt_pkg::FUNC_SELECT_OFFSET);
  assign dp_csr_wr   = s_q.dp_active && s_q.dp_write &&
                       (s_q.dp_addr == uart_alt_pkg::ALT_CSR_OFFSET);
  assign dp_fsel_wr  = s_q.dp_active && s_q.dp_write &&
                       (s_q.dp_addr == uart_alt_pkg::FUNC_SELECT_OFFSET);
  assign rs485_on    = (s_q.func == uart_alt_pkg::FUNC_RS485);

  uart_break_gen u_break (
    .clk_in        (CLK_IN),
    .resetn_in     (RESETN_IN),
    .start_in      (s_q.start),
    .count_in      (s_q.ctrl.break_length_count),
    .bit_cycles_in (BIT_CYCLES_IN),
    .active_out    (brk_active),
    .done_out      (brk_done)
  );

  function automatic logic [31:0] pack_csr(input uart_alt_pkg::alt_ctrl_t c);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[uart_alt_pkg::MATCH_LSB +: 8]       = c.station_match;
    v[uart_alt_pkg::ADDR_EN_BIT]          = c.multidrop_addr_detect_enable;
    v[uart_alt_pkg::AUTO_DIR_BIT]         = c.auto_direction_mode;
    v[uart_alt_pkg::AUTO_ADDR_BIT]        = c.auto_address_detect_mode;
    v[uart_alt_pkg::NORMAL_MD_BIT]        = c.normal_multidrop_mode;
    v[uart_alt_pkg::BREAK_REQ_BIT]        = c.break_request;
    v[uart_alt_pkg::LIN_RX_BIT]           = c.lin_rx_enable;
    v[3:0]                                = c.break_length_count;
    return v;
  endfunction

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    accept    = 1'b0;
    // address phase capture; the read word is taken here, so a read that
    // directly follows a write to the same register returns the old word
    if (HREADY_IN) begin
      s_d.dp_active = addr_req;
      s_d.dp_write  = HWRITE_IN && word_access;
      s_d.dp_addr   = HADDR_IN[7:0];
      s_d.rdata     = 32'h0000_0000;
      if (addr_req && !HWRITE_IN && word_access) begin
        if (csr_sel) begin
          s_d.rdata = pack_csr(s_q.ctrl);
        end else if (fsel_sel) begin
          s_d.rdata = {30'h0000_0000, s_q.func};
        end
      end
    end
    // data phase write; unmapped addresses are ignored
    if (dp_csr_wr || dp_fsel_wr) begin
      if (dp_csr_wr) begin
        s_d.ctrl.station_match = HWDATA_IN[uart_alt_pkg::MATCH_LSB +: 8];
        s_d.ctrl.multidrop_addr_detect_enable =
          HWDATA_IN[uart_alt_pkg::ADDR_EN_BIT];
        s_d.ctrl.auto_direction_mode = HWDATA_IN[uart_alt_pkg::AUTO_DIR_BIT];
        // exclusivity of the two multi-drop modes is left to software
        s_d.ctrl.auto_address_detect_mode = HWDATA_IN[uart_alt_pkg::AUTO_ADDR_BIT];
        s_d.ctrl.normal_multidrop_mode    = HWDATA_IN[uart_alt_pkg::NORMAL_MD_BIT];
        s_d.ctrl.lin_rx_enable            = HWDATA_IN[uart_alt_pkg::LIN_RX_BIT];
        s_d.ctrl.break_length_count       = HWDATA_IN[3:0];
        // writing 0 does not abort a running break; writing 1 starts one only when break_request is clear
        if (HWDATA_IN[uart_alt_pkg::BREAK_REQ_BIT] && !s_q.ctrl.break_request) begin
          s_d.ctrl.break_request = 1'b1;
          s_d.start              = 1'b1;
        end
      end else begin
        s_d.func = HWDATA_IN[1:0];
      end
    end
    // self-clear once the break has gone out
    if (brk_done) begin
      s_d.ctrl.break_request = 1'b0;
    end
    // direction follows the frame, released when the stop bit has left
    s_d.tx_dir = rs485_on && s_q.ctrl.auto_direction_mode && TX_FRAME_ACTIVE_IN;
    // receive filtering
    s_d.rx_out.valid = 1'b0;
    if (RX_VALID_IN) begin
      if (rs485_on && s_q.ctrl.auto_address_detect_mode) begin
        if (RX_IS_ADDR_IN) begin
          s_d.matched = (RX_DATA_IN == s_q.ctrl.station_match);
          // address byte passed up only when detection is enabled and it matched
          accept = s_q.ctrl.multidrop_addr_detect_enable &&
                   (RX_DATA_IN == s_q.ctrl.station_match);
        end else begin
          accept = s_q.matched;
        end
      end else begin
        accept = !(rs485_on && s_q.ctrl.normal_multidrop_mode && RX_IS_ADDR_IN &&
                   !s_q.ctrl.multidrop_addr_detect_enable);
      end
      if (accept) begin
        s_d.rx_out.valid      = 1'b1;
        s_d.rx_out.data       = RX_DATA_IN;
        s_d.rx_out.is_address = RX_IS_ADDR_IN;
      end
    end
    if (!s_q.ctrl.auto_address_detect_mode) begin
      s_d.matched = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s_q                         <= '0;
      s_q.ctrl.break_length_count <= uart_alt_pkg::BREAK_LEN_RESET;
      s_q.func                    <= uart_alt_pkg::FUNC_UART;
    end else begin
      s_q <= s_d;
    end
  end

  assign HRDATA_OUT           = s_q.rdata;
  assign HREADYOUT_OUT        = 1'b1;
  assign HRESP_OUT            = 1'b0;
  assign TX_BREAK_OUT         = brk_active;
  assign TX_DIR_OUT           = s_q.tx_dir;
  assign RX_VALID_OUT         = s_q.rx_out.valid;
  assign RX_DATA_OUT          = s_q.rx_out.data;
  assign ADDR_MATCHED_OUT     = s_q.matched;
  assign CHANNEL_FUNCTION_OUT = s_q.func;
  assign LIN_RX_ENABLE_OUT    = s_q.ctrl.lin_rx_enable;
endmodule

/* File: verif/uart_alt_assertions.sv */
`timescale 1ns/1ps
module uart_alt_assertions (
  // bus
  input wire logic        CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic        HREADY_IN,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  // line
  input wire logic [15:0] BIT_CYCLES_IN,
  input wire logic        TX_FRAME_ACTIVE_IN,
  input wire logic        RX_VALID_IN,
  input wire logic [7:0]  RX_DATA_IN,
  input wire logic        TX_BREAK_OUT,
  input wire logic        TX_DIR_OUT,
  input wire logic        RX_VALID_OUT,
  input wire logic [7:0]  RX_DATA_OUT,
  input wire logic [1:0]  CHANNEL_FUNCTION_OUT,
  input wire logic        LIN_RX_ENABLE_OUT
);
  logic        fn_wr_q;
  logic        csr_wr_q;
  logic [15:0] brk_q;
  wire         wr = HSEL_IN && HTRANS_IN[1] && HREADY_IN && HWRITE_IN;
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      fn_wr_q <= 1'b0;
      csr_wr_q <= 1'b0;
      brk_q <= 16'h0000;
    end else begin
      fn_wr_q <= wr && HADDR_IN[7:0] == uart_alt_pkg::FUNC_SELECT_OFFSET;
      csr_wr_q <= wr && HADDR_IN[7:0] == uart_alt_pkg::ALT_CSR_OFFSET;
      brk_q <= TX_BREAK_OUT ? brk_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // register writes land one to three edges after the address phase
  sequence s_csr_wr;
    $past(csr_wr_q) || $past(csr_wr_q, 2) || $past(csr_wr_q, 3);
  endsequence
  property p_bus; HREADYOUT_OUT && !HRESP_OUT; endproperty
  property p_dir_on;
    TX_DIR_OUT |-> CHANNEL_FUNCTION_OUT == 2'h3 && $past(TX_FRAME_ACTIVE_IN);
  endproperty
  property p_dir_off; !TX_FRAME_ACTIVE_IN |=> !TX_DIR_OUT; endproperty
  property p_brk_go; $rose(TX_BREAK_OUT) |-> s_csr_wr; endproperty
  property p_brk_len;
    $fell(TX_BREAK_OUT) |-> brk_q >= BIT_CYCLES_IN && brk_q % BIT_CYCLES_IN == 16'h0000;
  endproperty
  property p_rx_src;
    RX_VALID_OUT |-> $past(RX_VALID_IN) && RX_DATA_OUT == $past(RX_DATA_IN);
  endproperty
  property p_rx_pass; RX_VALID_IN && CHANNEL_FUNCTION_OUT != 2'h3 |=> RX_VALID_OUT; endproperty
  property p_fn;
    $changed(CHANNEL_FUNCTION_OUT) |-> $past(fn_wr_q) || $past(fn_wr_q, 2);
  endproperty
  property p_lin; $changed(LIN_RX_ENABLE_OUT) |-> s_csr_wr; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready okay");
  a_dir_on: assert property (p_dir_on) else $error("direction without frame");
  a_dir_off: assert property (p_dir_off) else $error("direction held");
  a_brk_go: assert property (p_brk_go) else $error("break without request");
  a_brk_len: assert property (p_brk_len) else $error("break length");
  a_rx_src: assert property (p_rx_src) else $error("rx without source");
  a_rx_pass: assert property (p_rx_pass) else $error("rx dropped");
  a_fn: assert property (p_fn) else $error("function changed alone");
  a_lin: assert property (p_lin) else $error("lin rx changed alone");
endmodule
bind uart_alt_function_control uart_alt_assertions u_chk (
  .CLK_IN               (CLK_IN),
  .RESETN_IN            (RESETN_IN),
  .HSEL_IN              (HSEL_IN),
  .HADDR_IN             (HADDR_IN),
  .HTRANS_IN            (HTRANS_IN),
  .HWRITE_IN            (HWRITE_IN),
  .HREADY_IN            (HREADY_IN),
  .HREADYOUT_OUT        (HREADYOUT_OUT),
  .HRESP_OUT            (HRESP_OUT),
  .BIT_CYCLES_IN        (BIT_CYCLES_IN),
  .TX_FRAME_ACTIVE_IN   (TX_FRAME_ACTIVE_IN),
  .RX_VALID_IN          (RX_VALID_IN),
  .RX_DATA_IN           (RX_DATA_IN),
  .TX_BREAK_OUT         (TX_BREAK_OUT),
  .TX_DIR_OUT           (TX_DIR_OUT),
  .RX_VALID_OUT         (RX_VALID_OUT),
  .RX_DATA_OUT          (RX_DATA_OUT),
  .CHANNEL_FUNCTION_OUT (CHANNEL_FUNCTION_OUT),
  .LIN_RX_ENABLE_OUT    (LIN_RX_ENABLE_OUT)
);

/* File: verif/uart_line_node.sv */
`timescale 1ns/1ps
module uart_line_node (
  input  wire logic clk_in,
  output logic      frame_active_out,
  output logic      rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic      rx_is_addr_out
);
  initial begin
    frame_active_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_is_addr_out = 1'b0;
  end
  // ninth bit set marks an address; released lines show the inverse
  task automatic send_byte(input logic [7:0] d, input logic a);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= d;
    rx_is_addr_out <= a;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~d;
    rx_is_addr_out <= ~a;
  endtask
  task automatic send_frame(input int n);
    frame_active_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    frame_active_out <= 1'b0;
  endtask
endmodule

/* File: verif/uart_alt_function_control_test.sv */
`timescale 1ns/1ps
module uart_alt_function_control_test;
  logic CLK_IN = 1'b0, RESETN_IN = 1'b0, HSEL_IN = 1'b0, HWRITE_IN = 1'b0;
  logic [31:0] HADDR_IN = '0, HWDATA_IN = '0, HRDATA_OUT, rv;
  logic [1:0] HTRANS_IN = 2'h0, CHANNEL_FUNCTION_OUT;
  logic [2:0] HSIZE_IN = 3'h2;
  logic [15:0] BIT_CYCLES_IN = 16'h0003;
  logic [7:0] RX_DATA_IN, RX_DATA_OUT, rx_last;
  logic HREADYOUT_OUT, HRESP_OUT, TX_BREAK_OUT, TX_DIR_OUT, RX_VALID_OUT, ADDR_MATCHED_OUT;
  logic TX_FRAME_ACTIVE_IN, RX_VALID_IN, RX_IS_ADDR_IN, LIN_RX_ENABLE_OUT;
  wire HREADY_IN = HREADYOUT_OUT;
  int err_total = 0, checks = 0, cyc = 0, rx_n = 0, brk_n = 0;
  uart_alt_function_control u_dut (.*);
  uart_line_node u_node (.clk_in(CLK_IN), .frame_active_out(TX_FRAME_ACTIVE_IN),
    .rx_valid_out(RX_VALID_IN), .rx_data_out(RX_DATA_IN), .rx_is_addr_out(RX_IS_ADDR_IN));
  initial forever #5 CLK_IN = ~CLK_IN;
  task end_of_test;
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // ready and read data are taken at the rising edge, before that edge's updates land
  task xfer(input logic w, input logic [31:0] a, d);
    HSEL_IN <= 1'b1;
    HTRANS_IN <= 2'h2;
    HADDR_IN <= a;
    HWRITE_IN <= w;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    HSEL_IN <= 1'b0;
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= d;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    rv = HRDATA_OUT;
  endtask
  task rdc(input logic [31:0] a, e);
    xfer(1'b0, a, '0);
    chk($sformatf("reg_%h", a[7:0]), rv, e);
  endtask
  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  always @(negedge CLK_IN) begin
    if (RX_VALID_OUT === 1'b1) begin
      rx_n++;
      rx_last = RX_DATA_OUT;
    end
    if (TX_BREAK_OUT === 1'b1) brk_n++;
  end
  initial begin
    repeat (8) @(posedge CLK_IN);
    RESETN_IN <= 1'b1;
    @(posedge CLK_IN);
    rdc(32'h0000_002C, 32'h0000_000C);
    rdc(32'h0000_0030, 32'h0000_0000);
    xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    rdc(32'h0000_0040, 32'h0000_0000);
    for (int f = 0; f < 4; f++) begin
      xfer(1'b1, 32'h0000_0030, 32'(f));
      rdc(32'h0000_0030, 32'(f));
      chk("func", 32'(CHANNEL_FUNCTION_OUT), 32'(f));
      u_node.send_byte(8'hA0, 1'b0);
    end
    xfer(1'b1, 32'h0000_002C, 32'h0000_008C);
    repeat (50) @(posedge CLK_IN);
    rdc(32'h0000_002C, 32'h0000_000C);
    chk("break", 32'(brk_n), 32'h0000_0027);
    xfer(1'b1, 32'h0000_002C, 32'h5A00_8641);
    rdc(32'h0000_002C, 32'h5A00_8641);
    chk("lin_rx", 32'(LIN_RX_ENABLE_OUT), 32'h0000_0001);
    rx_n = 0;
    u_node.send_byte(8'h11, 1'b0);
    u_node.send_byte(8'h33, 1'b1);
    repeat (2) @(posedge CLK_IN);
    chk("drop", 32'(rx_n), 32'h0000_0000);
    u_node.send_byte(8'h5A, 1'b1);
    u_node.send_byte(8'h22, 1'b0);
    repeat (2) @(posedge CLK_IN);
    chk("rx", 32'(rx_last), 32'h0000_0022);
    chk("match", 32'(ADDR_MATCHED_OUT), 32'h0000_0001);
    fork
      u_node.send_frame(6);
      begin
        repeat (3) @(posedge CLK_IN);
        chk("dir", 32'(TX_DIR_OUT), 32'h0000_0001);
      end
    join
    repeat (2) @(posedge CLK_IN);
    chk("dir_off", 32'(TX_DIR_OUT), 32'h0000_0000);
    RESETN_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    RESETN_IN <= 1'b1;
    @(posedge CLK_IN);
    rdc(32'h0000_002C, 32'h0000_000C);
    chk("func_rst", 32'(CHANNEL_FUNCTION_OUT), 32'h0000_0000);
    chk("match_rst", 32'(ADDR_MATCHED_OUT), 32'h0000_0000);
    end_of_test();
  end
endmodule
